/* hw/chgseq_pkg.sv */
// Constants, register map and types of the charge sequencer and safety timer.
package chgseq_pkg;
   // -----------------------------------------------------------------
   // Clock and timing
   // -----------------------------------------------------------------
   localparam int CLK_MHZ = 40;
   localparam int TICK_US = 1000;
   localparam int TICK_CYC = TICK_US * CLK_MHZ;
   localparam int SHORT_S = 32;
   localparam int SHORT_TICKS = SHORT_S * 1000000 / TICK_US;
   localparam int LONG_MIN = 32;
   localparam int LONG_TICKS = LONG_MIN * 60 * 1000000 / TICK_US;
   localparam int PULSE_US = 128;
   localparam int PULSE_CYC = PULSE_US * CLK_MHZ;
   localparam int SW_KHZ = 3000;
   localparam int PWM_PERIOD_CYC = CLK_MHZ * 1000 / SW_KHZ;
   localparam int DUTY_MAX_PERMILLE = 995;
   localparam int PWM_MAX_ON_CYC = PWM_PERIOD_CYC * DUTY_MAX_PERMILLE / 1000;
   localparam int DEB_CYC = 15;
   localparam int PW = 16;
   localparam int TW = 21;
   localparam int SW = 13;
   // -----------------------------------------------------------------
   // Comparator inputs
   // -----------------------------------------------------------------
   localparam int IN_SHORT = 0;
   localparam int IN_RECH = 1;
   localparam int IN_WEAK = 2;
   localparam int IN_TERM = 3;
   localparam int IN_THERM = 4;
   localparam int IN_HSLIM = 5;
   localparam int IN_LSHI = 6;
   localparam int IN_BUSPOR = 7;
   localparam int NIN = 8;
   localparam int NDEB = 5;
   // -----------------------------------------------------------------
   // Registers
   // -----------------------------------------------------------------
   localparam logic [1:0] ADDR_STATUS = 2'h0;
   localparam logic [1:0] ADDR_CTRL = 2'h1;
   localparam logic [1:0] ADDR_VREG = 2'h2;
   localparam logic [1:0] ADDR_CURR = 2'h3;
   localparam int CTRL_BOOST = 0;
   localparam int CTRL_HZ = 1;
   localparam int CTRL_CE = 2;
   localparam int CTRL_TERM_EN = 3;
   localparam int CTRL_STAT_EN = 4;
   localparam int CTRL_RESET = 6;
   localparam int CTRL_KICK = 7;
   localparam logic [7:0] CTRL_RST = 8'h04;
   localparam logic [5:0] VREG_RST = 6'h02;
   localparam logic [5:0] VREG_MAX = 6'h2F;
   localparam logic [1:0] IIN_RST = 2'h0;
   localparam logic [2:0] ICHG_RST = 3'h0;
   localparam logic [2:0] TERMINATION_CURRENT_THRESHOLD_RST = 3'h1;
   localparam logic [2:0] ICHG_IIN100_CAP = 3'h1;
   localparam logic [1:0] COND_READY = 2'h0;
   localparam logic [1:0] COND_CHARGING = 2'h1;
   localparam logic [1:0] COND_DONE = 2'h2;
   localparam logic [1:0] COND_FAULT = 2'h3;

   typedef enum logic [2:0] {ST_OFF, ST_PRE, ST_FAST, ST_DONE, ST_FAULT} chgseq_state_t;

   typedef struct packed {
      logic [7:0] ctrl;
      logic [5:0] vreg;
      logic [1:0] iin;
      logic [2:0] ichg;
      logic [2:0] termination_current_threshold;
   } chgseq_cfg_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } chgseq_bus_t;
endpackage : chgseq_pkg

/* hw/chgseq_top.sv */
// Charge sequencer with two-stage safety timer, indicator pin and register port.
//
// The plain strobed port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
module chgseq_top #(
   parameter int TICK_CYC = chgseq_pkg::TICK_CYC,
   parameter int SHORT_TICKS = chgseq_pkg::SHORT_TICKS,
   parameter int LONG_TICKS = chgseq_pkg::LONG_TICKS,
   parameter int PULSE_CYC = chgseq_pkg::PULSE_CYC,
   parameter bit AUTO_CHARGE = 1'b1
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire chgseq_pkg::chgseq_bus_t bus,
   output logic [7:0] rdata,
   input wire logic [chgseq_pkg::NIN-1:0] cmp_in,
   input wire logic [3:0] duty_cmd,
   output logic high_side_switch_on,
   output logic low_side_switch_on,
   output logic blocking_switch_on,
   output logic precharge_en,
   output logic boost_en,
   output logic hz_en,
   output logic [2:0] ichg_level,
   output chgseq_pkg::chgseq_cfg_t cfg_out,
   output logic stat_o,
   output logic stat_oe
);
   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   typedef struct packed {
      logic [chgseq_pkg::NIN-1:0] s1;
      logic [chgseq_pkg::NIN-1:0] s2;
      logic [chgseq_pkg::NDEB-1:0] db;
      logic [chgseq_pkg::NDEB-1:0][3:0] dbc;
      logic bus_por_prev;
      chgseq_pkg::chgseq_state_t st;
      chgseq_pkg::chgseq_cfg_t cfg;
      logic ce_prev;
      logic therm;
      logic mode_short;
      logic [chgseq_pkg::PW-1:0] presc;
      logic [chgseq_pkg::TW-1:0] tmr;
      logic fault;
      logic [2:0] ramp;
      logic [3:0] pwm_cnt;
      logic hs_on;
      logic ls_on;
      logic [chgseq_pkg::SW-1:0] pulse_cnt;
      logic stat_oe;
      logic [7:0] status;
      logic rd_seen;
      logic [7:0] rdata;
      logic blk_on;
      logic pre_en;
      logic boost_on;
   } chgseq_regs_t;

   chgseq_regs_t r_q;
   chgseq_regs_t r_d;
   logic [7:0] live_status;
   logic charging;
   logic tick;
   logic start_chg;
   logic short_exp;
   logic long_exp;
   logic restart;
   logic [2:0] ramp_tgt;
   logic fault_evt;
   logic [3:0] duty_lim;

   assign charging = (r_q.st == chgseq_pkg::ST_PRE) || (r_q.st == chgseq_pkg::ST_FAST);
   assign tick = r_q.presc == chgseq_pkg::PW'(TICK_CYC - 1);
   assign short_exp = r_q.mode_short && tick && !r_q.therm && charging &&
                      r_q.tmr >= chgseq_pkg::TW'(SHORT_TICKS - 1);
   assign long_exp = !r_q.mode_short && tick && !r_q.therm && charging &&
                     r_q.tmr >= chgseq_pkg::TW'(LONG_TICKS - 1);
   assign live_status = {r_q.mode_short, r_q.therm, 1'b0, r_q.fault, 1'b0, r_q.st == chgseq_pkg::ST_PRE,
                         r_q.fault ? chgseq_pkg::COND_FAULT :
                         (r_q.st == chgseq_pkg::ST_DONE) ? chgseq_pkg::COND_DONE :
                         charging ? chgseq_pkg::COND_CHARGING : chgseq_pkg::COND_READY};

   always_comb begin
      r_d = r_q;
      restart = 1'b0;
      start_chg = 1'b0;
      fault_evt = 1'b0;
      // -----------------------------------------------------------------
      // Input synchronisers and debounce
      // -----------------------------------------------------------------
      r_d.s1 = cmp_in;
      r_d.s2 = r_q.s1;
      for (int i = 0; i < chgseq_pkg::NDEB; i++) begin
         if (r_q.s2[i] == r_q.db[i]) begin
            r_d.dbc[i] = 4'h0;
         end else if (r_q.dbc[i] == 4'(chgseq_pkg::DEB_CYC)) begin
            r_d.db[i] = r_q.s2[i];
            r_d.dbc[i] = 4'h0;
         end else begin
            r_d.dbc[i] = r_q.dbc[i] + 4'h1;
         end
      end
      r_d.bus_por_prev = r_q.s2[chgseq_pkg::IN_BUSPOR];
      r_d.therm = r_q.db[chgseq_pkg::IN_THERM];
      // -----------------------------------------------------------------
      // Register port
      // -----------------------------------------------------------------
      r_d.cfg.ctrl[chgseq_pkg::CTRL_KICK] = 1'b0;
      r_d.cfg.ctrl[chgseq_pkg::CTRL_RESET] = 1'b0;
      r_d.rdata = 8'h00;
      if (bus.rd) begin
         unique case (bus.addr[1:0])
            chgseq_pkg::ADDR_STATUS: r_d.rdata = r_q.status;
            chgseq_pkg::ADDR_CTRL: r_d.rdata = r_q.cfg.ctrl;
            chgseq_pkg::ADDR_VREG: r_d.rdata = {2'h0, r_q.cfg.vreg};
            chgseq_pkg::ADDR_CURR: r_d.rdata = {r_q.cfg.iin, r_q.cfg.ichg, r_q.cfg.termination_current_threshold};
         endcase
         if (bus.addr[7:2] != 6'h00) begin
            r_d.rdata = 8'h00;
         end
      end
      if (bus.wr && bus.addr[7:2] == 6'h00) begin
         unique case (bus.addr[1:0])
            chgseq_pkg::ADDR_STATUS: r_d.cfg = r_q.cfg;
            chgseq_pkg::ADDR_CTRL: r_d.cfg.ctrl = bus.wdata;
            chgseq_pkg::ADDR_VREG: r_d.cfg.vreg = (bus.wdata[5:0] > chgseq_pkg::VREG_MAX) ?
                                                  chgseq_pkg::VREG_MAX : bus.wdata[5:0];
            chgseq_pkg::ADDR_CURR: begin
               r_d.cfg.iin = bus.wdata[7:6];
               r_d.cfg.ichg = bus.wdata[5:3];
               r_d.cfg.termination_current_threshold = bus.wdata[2:0];
            end
         endcase
      end
      // -----------------------------------------------------------------
      // Safety timers
      // -----------------------------------------------------------------
      r_d.presc = tick ? '0 : r_q.presc + 1'b1;
      if (tick && !r_q.therm && charging) begin
         r_d.tmr = r_q.tmr + 1'b1;
      end
      if (bus.wr) begin
         r_d.mode_short = 1'b1;
         if (!r_q.mode_short || (bus.addr[1:0] == chgseq_pkg::ADDR_CTRL && bus.wdata[chgseq_pkg::CTRL_KICK])) begin
            r_d.tmr = '0;
         end
      end
      // -----------------------------------------------------------------
      // Charge sequencer
      // -----------------------------------------------------------------
      r_d.ce_prev = r_q.cfg.ctrl[chgseq_pkg::CTRL_CE];
      if (r_q.cfg.ctrl[chgseq_pkg::CTRL_CE] && !r_q.ce_prev) begin
         restart = 1'b1;
      end
      if (r_q.cfg.ctrl[chgseq_pkg::CTRL_RESET]) begin
         restart = 1'b1;
         r_d.cfg.vreg = chgseq_pkg::VREG_RST;
         r_d.cfg.iin = chgseq_pkg::IIN_RST;
         r_d.cfg.ichg = chgseq_pkg::ICHG_RST;
         r_d.cfg.termination_current_threshold = chgseq_pkg::TERMINATION_CURRENT_THRESHOLD_RST;
      end
      if (AUTO_CHARGE && r_q.s2[chgseq_pkg::IN_BUSPOR] && !r_q.bus_por_prev && r_q.db[chgseq_pkg::IN_WEAK]) begin
         restart = 1'b1;
         r_d.cfg.ctrl[chgseq_pkg::CTRL_CE] = 1'b1;
      end
      if (short_exp) begin
         r_d.cfg = '{ctrl: chgseq_pkg::CTRL_RST, vreg: chgseq_pkg::VREG_RST, iin: chgseq_pkg::IIN_RST,
                     ichg: chgseq_pkg::ICHG_RST, termination_current_threshold: chgseq_pkg::TERMINATION_CURRENT_THRESHOLD_RST};
         r_d.mode_short = 1'b0;
         restart = 1'b1;
      end
      unique case (r_q.st)
         chgseq_pkg::ST_OFF: begin
            if (r_q.cfg.ctrl[chgseq_pkg::CTRL_CE]) begin
               start_chg = 1'b1;
            end
         end
         chgseq_pkg::ST_PRE: begin
            if (!r_q.db[chgseq_pkg::IN_SHORT]) begin
               r_d.st = chgseq_pkg::ST_FAST;
            end
         end
         chgseq_pkg::ST_FAST: begin
            if (r_q.db[chgseq_pkg::IN_SHORT]) begin
               r_d.st = chgseq_pkg::ST_PRE;
            end else if (r_q.cfg.ctrl[chgseq_pkg::CTRL_TERM_EN] && r_q.db[chgseq_pkg::IN_TERM] &&
                         r_q.db[chgseq_pkg::IN_RECH]) begin
               r_d.st = chgseq_pkg::ST_DONE;
            end
         end
         chgseq_pkg::ST_DONE: begin
            if (!r_q.db[chgseq_pkg::IN_RECH]) begin
               start_chg = 1'b1;
            end
         end
         chgseq_pkg::ST_FAULT: begin
            r_d.st = chgseq_pkg::ST_FAULT;
         end
      endcase
      if (restart && r_q.st != chgseq_pkg::ST_FAULT) begin
         start_chg = 1'b1;
      end
      if (start_chg) begin
         r_d.st = chgseq_pkg::ST_PRE;
         r_d.tmr = '0;
         r_d.ramp = 3'h0;
      end
      if (!r_d.cfg.ctrl[chgseq_pkg::CTRL_CE] || r_d.cfg.ctrl[chgseq_pkg::CTRL_HZ] ||
          r_d.cfg.ctrl[chgseq_pkg::CTRL_BOOST]) begin
         if (r_q.st != chgseq_pkg::ST_FAULT) begin
            r_d.st = chgseq_pkg::ST_OFF;
         end
      end
      if (long_exp) begin
         r_d.st = chgseq_pkg::ST_FAULT;
         r_d.fault = 1'b1;
         fault_evt = 1'b1;
      end
      if (r_q.db[chgseq_pkg::IN_THERM] && !r_q.therm) begin
         fault_evt = 1'b1;
      end
      // -----------------------------------------------------------------
      // Current ramp and switching
      // -----------------------------------------------------------------
      ramp_tgt = (r_q.cfg.iin == chgseq_pkg::IIN_RST && r_q.cfg.ichg > chgseq_pkg::ICHG_IIN100_CAP) ?
                 chgseq_pkg::ICHG_IIN100_CAP : r_q.cfg.ichg;
      if (r_q.st != chgseq_pkg::ST_FAST) begin
         r_d.ramp = 3'h0;
      end else if (tick && r_q.ramp < ramp_tgt) begin
         r_d.ramp = r_q.ramp + 3'h1;
      end else if (r_q.ramp > ramp_tgt) begin
         r_d.ramp = ramp_tgt;
      end
      duty_lim = (duty_cmd > 4'(chgseq_pkg::PWM_MAX_ON_CYC)) ? 4'(chgseq_pkg::PWM_MAX_ON_CYC) : duty_cmd;
      r_d.pwm_cnt = (r_q.pwm_cnt == 4'(chgseq_pkg::PWM_PERIOD_CYC - 1)) ? 4'h0 : r_q.pwm_cnt + 4'h1;
      if (r_q.st == chgseq_pkg::ST_FAST && !r_q.therm && r_d.st == chgseq_pkg::ST_FAST) begin
         r_d.hs_on = (r_d.pwm_cnt < duty_lim) && !(r_q.hs_on && r_q.s2[chgseq_pkg::IN_HSLIM]) &&
                     (r_d.pwm_cnt == 4'h0 || r_q.hs_on);
         r_d.ls_on = !r_d.hs_on && !r_q.hs_on && r_q.s2[chgseq_pkg::IN_LSHI];
      end else begin
         r_d.hs_on = 1'b0;
         r_d.ls_on = 1'b0;
      end
      // -----------------------------------------------------------------
      // Indicator pin
      // -----------------------------------------------------------------
      if (fault_evt) begin
         r_d.pulse_cnt = chgseq_pkg::SW'(PULSE_CYC);
      end else if (r_q.pulse_cnt != '0) begin
         r_d.pulse_cnt = r_q.pulse_cnt - 1'b1;
      end
      r_d.stat_oe = (r_d.pulse_cnt != '0) ||
                    ((r_d.st == chgseq_pkg::ST_PRE || r_d.st == chgseq_pkg::ST_FAST) &&
                     r_d.cfg.ctrl[chgseq_pkg::CTRL_STAT_EN]);
      // -----------------------------------------------------------------
      // Registered outputs
      // -----------------------------------------------------------------
      // Derived outputs are registered from the next state so that they keep the timing of the bits they follow.
      r_d.blk_on = r_d.hs_on || r_d.ls_on;
      r_d.pre_en = (r_d.st == chgseq_pkg::ST_PRE) && !r_d.therm;
      r_d.boost_on = r_d.cfg.ctrl[chgseq_pkg::CTRL_BOOST] && !r_d.cfg.ctrl[chgseq_pkg::CTRL_HZ];
      // -----------------------------------------------------------------
      // Status snapshot
      // -----------------------------------------------------------------
      if (bus.rd && bus.addr == 8'h00) begin
         r_d.rd_seen = 1'b1;
      end
      if (r_q.rd_seen && live_status != r_q.status) begin
         r_d.status = live_status;
         r_d.rd_seen = 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         r_q <= '0;
         r_q.st <= chgseq_pkg::ST_OFF;
         r_q.cfg <= '{ctrl: chgseq_pkg::CTRL_RST, vreg: chgseq_pkg::VREG_RST, iin: chgseq_pkg::IIN_RST,
                      ichg: chgseq_pkg::ICHG_RST, termination_current_threshold: chgseq_pkg::TERMINATION_CURRENT_THRESHOLD_RST};
         r_q.rd_seen <= 1'b1;
         // The battery counts as shorted until the comparator proves otherwise, so no switching starts early.
         r_q.db[chgseq_pkg::IN_SHORT] <= 1'b1;
      end else begin
         r_q <= r_d;
      end
   end

   assign rdata = r_q.rdata;
   assign high_side_switch_on = r_q.hs_on;
   assign low_side_switch_on = r_q.ls_on;
   assign blocking_switch_on = r_q.blk_on;
   assign precharge_en = r_q.pre_en;
   assign boost_en = r_q.boost_on;
   assign hz_en = r_q.cfg.ctrl[chgseq_pkg::CTRL_HZ];
   assign ichg_level = r_q.ramp;
   assign cfg_out = r_q.cfg;
   assign stat_o = 1'b0;
   assign stat_oe = r_q.stat_oe;

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   chk_hz_halts: assert property (@(posedge clk_sys) disable iff (reset)
      r_q.cfg.ctrl[chgseq_pkg::CTRL_HZ] |=> !r_q.hs_on && !r_q.ls_on)
      else $error("switching while in high impedance mode");
   chk_hs_limit: assert property (@(posedge clk_sys) disable iff (reset)
      r_q.hs_on && r_q.s2[chgseq_pkg::IN_HSLIM] |=> !r_q.hs_on)
      else $error("high side stayed on past current limit");
   chk_ls_sync: assert property (@(posedge clk_sys) disable iff (reset)
      r_q.ls_on |-> $past(r_q.s2[chgseq_pkg::IN_LSHI]))
      else $error("low side on with low current");
   chk_pre_nopwm: assert property (@(posedge clk_sys) disable iff (reset)
      r_q.st == chgseq_pkg::ST_PRE |-> !r_q.hs_on)
      else $error("switching during precharge");
   chk_no_term: assert property (@(posedge clk_sys) disable iff (reset)
      r_q.st == chgseq_pkg::ST_FAST && !r_q.cfg.ctrl[chgseq_pkg::CTRL_TERM_EN] |=> r_q.st != chgseq_pkg::ST_DONE)
      else $error("terminated with termination disabled");
   chk_kick_clear: assert property (@(posedge clk_sys) disable iff (reset)
      r_q.cfg.ctrl[chgseq_pkg::CTRL_KICK] |=> !r_q.cfg.ctrl[chgseq_pkg::CTRL_KICK])
      else $error("kick bit did not clear");
   chk_write_short: assert property (@(posedge clk_sys) disable iff (reset)
      bus.wr && !short_exp |=> r_q.mode_short ##1 r_q.mode_short || $past(short_exp))
      else $error("write did not select watchdog timer");
   chk_long_fault: assert property (@(posedge clk_sys) disable iff (reset)
      long_exp |=> r_q.st == chgseq_pkg::ST_FAULT && r_q.fault ##1 r_q.status[1:0] == chgseq_pkg::COND_FAULT
      || !r_q.rd_seen || $past(!r_q.rd_seen))
      else $error("long timer expiry without fault");
   chk_fault_stick: assert property (@(posedge clk_sys) disable iff (reset)
      r_q.fault |=> r_q.fault && r_q.st == chgseq_pkg::ST_FAULT)
      else $error("timer fault cleared without reset");
   chk_fault_pulse: assert property (@(posedge clk_sys) disable iff (reset)
      fault_evt |=> r_q.stat_oe [*8])
      else $error("no fault pulse on indicator");
   chk_therm_freeze: assert property (@(posedge clk_sys) disable iff (reset)
      r_q.therm && $past(r_q.therm) |-> $stable(r_q.tmr) || $past(start_chg) || $past(bus.wr))
      else $error("timer ran in thermal shutdown");
   chk_therm_off: assert property (@(posedge clk_sys) disable iff (reset)
      r_q.therm |=> !r_q.hs_on && !r_q.ls_on)
      else $error("switching during thermal shutdown");
   chk_pwm_period: assert property (@(posedge clk_sys) disable iff (reset)
      r_q.pwm_cnt <= 4'(chgseq_pkg::PWM_PERIOD_CYC - 1))
      else $error("switching period counter out of range");
   chk_duty_max: assert property (@(posedge clk_sys) disable iff (reset)
      r_q.pwm_cnt == 4'(chgseq_pkg::PWM_PERIOD_CYC - 1) |-> !r_q.hs_on)
      else $error("high side on for the whole period");
   chk_kick_timer: assert property (@(posedge clk_sys) disable iff (reset)
      bus.wr && bus.addr[1:0] == chgseq_pkg::ADDR_CTRL && bus.wdata[chgseq_pkg::CTRL_KICK] |=> r_q.tmr == '0)
      else $error("kick did not restart the watchdog timer");
   chk_boost_hz: assert property (@(posedge clk_sys) disable iff (reset)
      r_q.cfg.ctrl[chgseq_pkg::CTRL_HZ] |-> !r_q.boost_on)
      else $error("boost enabled in high impedance mode");
   chk_status_hold: assert property (@(posedge clk_sys) disable iff (reset)
      !r_q.rd_seen |=> $stable(r_q.status))
      else $error("status changed before it was read");
endmodule : chgseq_top

/* verif/chgseq_host.sv */
// Host processor model that drives the register port of the charge sequencer.
`timescale 1ns/100ps
module chgseq_host (
   input wire logic clk_sys,
   output chgseq_pkg::chgseq_bus_t bus,
   input wire logic [7:0] rdata
);
   // ---------------------------------------------------------------
   // Bus cycles
   // ---------------------------------------------------------------
   initial begin
      bus = '0;
   end

   // Every write, kicks included, hands the safety timer to the host.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_sys);
      bus <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
   endtask : wr

   // Read data stand only in the cycle after the strobe.
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      bus <= '{addr: a, wdata: 8'h5A, wr: 1'b0, rd: 1'b1};
      @(posedge clk_sys);
      bus <= '{addr: ~a, wdata: 8'hA5, wr: 1'b0, rd: 1'b0};
      #1;
      d = rdata;
   endtask : rd
endmodule : chgseq_host

/* verif/chgseq_test.sv */
// Self-checking testbench of the charge sequencer and safety timer.
`timescale 1ns/100ps
module chgseq_test;
   // ---------------------------------------------------------------
   // Environment
   // ---------------------------------------------------------------
   localparam logic [7:0] A_ST = {6'h00, chgseq_pkg::ADDR_STATUS};
   localparam logic [7:0] A_CT = {6'h00, chgseq_pkg::ADDR_CTRL};
   localparam logic [7:0] A_VR = {6'h00, chgseq_pkg::ADDR_VREG};
   localparam logic [7:0] A_CU = {6'h00, chgseq_pkg::ADDR_CURR};
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic [chgseq_pkg::NIN-1:0] cmp_in = 8'h01;
   logic [3:0] duty_cmd = 4'h6;
   chgseq_pkg::chgseq_bus_t bus;
   chgseq_pkg::chgseq_cfg_t cfg_out;
   logic [7:0] rdata;
   logic high_side_switch_on, low_side_switch_on, blocking_switch_on, precharge_en;
   logic boost_en, hz_en, stat_o, stat_oe;
   logic [2:0] ichg_level;
   logic kick_on = 1'b0;
   logic [7:0] ctrl_v = 8'h04;
   int n_fail = 0;
   int checked = 0;
   int pulse;

   always #12.5 clk_sys = ~clk_sys;

   chgseq_host i_chgseq_host (.clk_sys(clk_sys), .bus(bus), .rdata(rdata));

   chgseq_top #(.TICK_CYC(4), .SHORT_TICKS(20), .LONG_TICKS(60), .PULSE_CYC(12), .AUTO_CHARGE(1'b1)) i_chgseq_top (
      .clk_sys(clk_sys), .reset(reset), .bus(bus), .rdata(rdata), .cmp_in(cmp_in), .duty_cmd(duty_cmd),
      .high_side_switch_on(high_side_switch_on), .low_side_switch_on(low_side_switch_on),
      .blocking_switch_on(blocking_switch_on), .precharge_en(precharge_en), .boost_en(boost_en), .hz_en(hz_en),
      .ichg_level(ichg_level), .cfg_out(cfg_out), .stat_o(stat_o), .stat_oe(stat_oe));

   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   // The status snapshot refreshes after a read, so it is read twice.
   task automatic rdchk(input string name, input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      i_chgseq_host.rd(a, d);
      if (a == A_ST) i_chgseq_host.rd(a, d);
      check(name, d, exp);
   endtask : rdchk

   task automatic wrc(input logic [7:0] d);
      ctrl_v = d;
      i_chgseq_host.wr(A_CT, d);
   endtask : wrc

   // Waits n cycles plus two per kick and keeps the watchdog alive while kick_on is set.
   task automatic idle(input int n);
      for (int i = 1; i <= n; i++) begin
         @(posedge clk_sys);
         if (kick_on && i % 24 == 0) i_chgseq_host.wr(A_CT, ctrl_v | 8'h80);
      end
   endtask : idle

   task automatic summarize;
      $display("Checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : summarize

   initial begin
      #100000;
      n_fail++;
      summarize();
   end

   // ---------------------------------------------------------------
   // Tests
   // ---------------------------------------------------------------
   initial begin
      repeat (2) @(posedge clk_sys);
      reset <= 1'b0;
      idle(30);
      rdchk("status_pre", A_ST, 8'h05);
      check("precharge_en", {7'h0, precharge_en}, 8'h01);
      rdchk("ctrl_rst", A_CT, 8'h04);
      rdchk("vreg_rst", A_VR, 8'h02);
      rdchk("curr_rst", A_CU, 8'h01);
      $display("Test reset done");
      kick_on = 1'b1;
      i_chgseq_host.wr(A_VR, 8'h3F);
      rdchk("vreg_clamp", A_VR, 8'h2F);
      check("cfg_vreg", {2'h0, cfg_out.vreg}, 8'h2F);
      i_chgseq_host.wr(A_CU, 8'h39);
      rdchk("curr_wr", A_CU, 8'h39);
      i_chgseq_host.wr(A_ST, 8'hFF);
      i_chgseq_host.wr(8'h04, 8'h55);
      rdchk("status_host", A_ST, 8'h85);
      rdchk("unmapped", 8'h04, 8'h00);
      $display("Test registers done");
      cmp_in <= 8'h00;
      idle(30);
      check("precharge_off", {7'h0, precharge_en}, 8'h00);
      check("ichg_cap", {7'h0, ichg_level <= 3'h1}, 8'h01);
      rdchk("status_fast", A_ST, 8'h81);
      cmp_in <= 8'h0A;
      idle(40);
      rdchk("no_term", A_ST, 8'h81);
      wrc(8'h0C);
      idle(30);
      rdchk("term_done", A_ST, 8'h82);
      cmp_in <= 8'h00;
      idle(40);
      rdchk("recharge", A_ST, 8'h81);
      $display("Test charge phases done");
      wrc(8'h1C);
      idle(4);
      check("stat_low", {7'h0, stat_oe}, 8'h01);
      wrc(8'h0C);
      idle(4);
      check("stat_open", {7'h0, stat_oe}, 8'h00);
      wrc(8'h0E);
      idle(4);
      check("hz_en", {7'h0, hz_en}, 8'h01);
      check("switches_hz", {5'h0, high_side_switch_on, low_side_switch_on, blocking_switch_on}, 8'h00);
      rdchk("status_hz", A_ST, 8'h80);
      wrc(8'h0D);
      idle(4);
      check("boost_en", {7'h0, boost_en}, 8'h01);
      wrc(8'h08);
      wrc(8'h0C);
      idle(30);
      rdchk("ce_restart", A_ST, 8'h81);
      $display("Test modes done");
      i_chgseq_host.wr(A_CT, 8'h8C);
      rdchk("kick_clear", A_CT, 8'h0C);
      kick_on = 1'b0;
      idle(130);
      rdchk("wd_ctrl", A_CT, 8'h04);
      rdchk("wd_vreg", A_VR, 8'h02);
      rdchk("wd_status", A_ST, 8'h01);
      $display("Test watchdog done");
      pulse = 0;
      repeat (300) begin
         @(posedge clk_sys);
         #1;
         if (stat_oe === 1'b1) pulse++;
      end
      check("fault_pulse", pulse[7:0], 8'h0C);
      rdchk("long_fault", A_ST, 8'h13);
      wrc(8'h08);
      wrc(8'h0C);
      idle(20);
      rdchk("fault_sticky", A_ST, 8'h93);
      check("charger_off", {6'h0, precharge_en, high_side_switch_on}, 8'h00);
      @(posedge clk_sys);
      reset <= 1'b1;
      repeat (2) @(posedge clk_sys);
      reset <= 1'b0;
      idle(30);
      rdchk("fault_por", A_ST, 8'h01);
      wrc(8'h00);
      cmp_in <= 8'h04;
      idle(30);
      cmp_in <= 8'h84;
      idle(30);
      rdchk("auto_ctrl", A_CT, 8'h04);
      $display("Test auto charge done");
      $display("Test long timer done");
      summarize();
   end
endmodule : chgseq_test
